// *** src/sic_map.svh ***
// register map, field positions, reset values and codes of the spi interrupt/crc block
// assumes inclusion by the top module and the testbench only
`ifndef SIC_MAP_SVH
`define SIC_MAP_SVH

// register indices; byte address is four times the index
`define SIC_IDX_IRQ_MASK      16'hc0cc
`define SIC_IDX_EVENT_FLAGS   16'hc0ce
`define SIC_IDX_EVENT_ACK     16'hc0d0
`define SIC_IDX_CHECKSUM      16'hc0d2

// interrupt mask / flags / ack field positions
`define SIC_BIT_BLOCK         0
`define SIC_BIT_TRANSMIT      1
`define SIC_BIT_RECEIVE       2
`define SIC_BIT_FIFO_ERR      7

// checksum setup field positions
`define SIC_BIT_POLY_HI       15
`define SIC_BIT_POLY_LO       14
`define SIC_BIT_CRC_EN        13
`define SIC_BIT_CRC_LOAD      12
`define SIC_BIT_CRC_RX_SRC    11
`define SIC_BIT_CRC_NONZERO   10
`define SIC_BIT_CRC_NONONES   9

// reset values
`define SIC_RST_IRQ_MASK      3'h0
`define SIC_RST_FLAGS         3'h0
`define SIC_RST_POLY_SEL      2'h0

// polynomial select codes and generator terms (implicit top term dropped)
`define SIC_POLY_CCITT        2'h0
`define SIC_POLY_CRC7         2'h1
`define SIC_POLY_ALT16        2'h2
`define SIC_POLY_RSVD         2'h3
`define SIC_GEN_CCITT         16'h1021
`define SIC_GEN_CRC7          16'h0009
`define SIC_GEN_ALT16         16'h8005
`define SIC_LEN_16            5'h10
`define SIC_LEN_7             5'h07
`define SIC_CRC7_MASK         16'h007f

// receive length
`define SIC_RX_FULL_BYTE      4'h8

// axi responses
`define SIC_RESP_OKAY         2'h0
`define SIC_RESP_SLVERR       2'h2

`endif

// *** src/sic_pkg.sv ***
// types of the spi interrupt/crc block
// assumes sic_map.svh sits beside it
package sic_pkg;

  typedef logic [1:0] sic_poly_t;

  typedef enum logic [2:0] {
    SIC_SEL_MASK  = 3'h0,
    SIC_SEL_FLAGS = 3'h1,
    SIC_SEL_ACK   = 3'h2,
    SIC_SEL_CRC   = 3'h3,
    SIC_SEL_NONE  = 3'h4
  } sic_sel_e;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  irq_mask;
    logic [2:0]  flags;
    logic        fifo_err;
    logic        irq;
    logic        tx_underflow;
    logic        rx_overflow;
    logic [3:0]  rx_bit_count;
    sic_poly_t   poly_sel;
    logic        crc_en;
    logic        crc_load;
    logic        crc_rx_src;
    logic        crc_src_rx;
    logic [15:0] crc_gen;
    logic [4:0]  crc_len;
    logic        crc_nonzero;
    logic        crc_nonones;
  } sic_state_s;

endpackage : sic_pkg

// *** src/sic_top.sv ***
// spi interrupt enable/status/clear and crc control, axi4-lite slave
// assumes shift engine, fifos and crc generator outside, all on clk_sys
//
// Contract
// - zero receive length means eight bits
// - mask bit 2 gates byte receive interrupt
// - mask bit 1 gates byte transmit interrupt
// - mask bit 0 gates block transfer interrupt
// - status bit 7 shows fifo error
// - error with empty/full means underflow/overflow
// - fifo init clears the fifo error
// - status bit 2 shows receive event pending
// - status bit 1 shows transmit event pending
// - status bit 0 shows block event pending
// - ack bit 1 clears transmit flag
// - ack bit 0 clears block flag
// - ack register holds nothing readable
// - code 00 selects ccitt sixteen bit
// - code 01 selects seven bit crc
// - code 10 alt sixteen, 11 sixteen
// - crc bit 13 enables calculation
// - crc bit 12 loads ones, reads zero
// - bit 11 picks crc stream, full duplex
// - bits 10/9 flag not-zero, not-ones
//
// Our own choice: register access over AXI4-Lite.
`include "sic_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sic_top
  import sic_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input  wire  logic              clk_sys,
  input  wire  logic              rst_n,
  input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic              s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire  logic [31:0]       s_axi_wdata,
  input  wire  logic [3:0]        s_axi_wstrb,
  input  wire  logic              s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire  logic              s_axi_bready,
  input  wire  logic [ADDR_W-1:0] s_axi_araddr,
  input  wire  logic              s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire  logic              s_axi_rready,
  input  wire  logic              byte_receive_event,
  input  wire  logic              byte_transmit_event,
  input  wire  logic              block_transfer_event,
  input  wire  logic              receive_flag_clear,
  input  wire  logic              fifo_error_event,
  input  wire  logic              fifo_init,
  input  wire  logic              tx_empty,
  input  wire  logic              rx_full,
  input  wire  logic              full_duplex,
  input  wire  logic [2:0]        rx_bit_length,
  input  wire  logic [15:0]       crc_value,
  output logic                    spi_irq,
  output logic                    tx_underflow,
  output logic                    rx_overflow,
  output logic [3:0]              rx_bit_count,
  output sic_poly_t               polynomial_select,
  output logic [15:0]             crc_generator,
  output logic [4:0]              crc_length,
  output logic                    crc_enable,
  output logic                    crc_load_ones,
  output logic                    crc_source_rx
);

  if (ADDR_W < 18 || ADDR_W > 32) begin : g_addr_chk
    $error("sic_top: ADDR_W must be 18..32");
  end

  sic_state_s st_reg;
  sic_state_s st_next;

  function automatic sic_sel_e decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-3:0] idx;
    idx = addr[ADDR_W-1:2];
    decode = SIC_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      if (idx == (ADDR_W-2)'(`SIC_IDX_IRQ_MASK))    decode = SIC_SEL_MASK;
      if (idx == (ADDR_W-2)'(`SIC_IDX_EVENT_FLAGS)) decode = SIC_SEL_FLAGS;
      if (idx == (ADDR_W-2)'(`SIC_IDX_EVENT_ACK))   decode = SIC_SEL_ACK;
      if (idx == (ADDR_W-2)'(`SIC_IDX_CHECKSUM))    decode = SIC_SEL_CRC;
    end
  endfunction : decode

  logic     wr_fire;
  logic     rd_fire;
  sic_sel_e wr_sel;
  sic_sel_e rd_sel;
  logic     lo_en;
  logic     hi_en;
  logic [2:0]  ack_clr;
  logic [2:0]  set_ev;
  logic [15:0] crc_chk;
  logic [15:0] rd_word;

  assign wr_fire = st_reg.awready && st_reg.wready;
  assign rd_fire = st_reg.arready && s_axi_arvalid;
  assign wr_sel  = decode(s_axi_awaddr);
  assign rd_sel  = decode(s_axi_araddr);
  assign lo_en   = wr_fire && s_axi_wstrb[0];
  assign hi_en   = wr_fire && s_axi_wstrb[1];

  always_comb begin
    st_next = st_reg;
    ack_clr = 3'h0;
    set_ev  = {byte_receive_event, byte_transmit_event, block_transfer_event};
    crc_chk = 16'h0000;
    rd_word = 16'h0000;

    // write channel: take address and data together
    st_next.awready = 1'b0;
    st_next.wready  = 1'b0;
    if (s_axi_awvalid && s_axi_wvalid && !st_reg.awready && !st_reg.bvalid) begin
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    st_next.crc_load = 1'b0;
    if (wr_fire) begin
      st_next.bvalid = 1'b1;
      st_next.bresp  = (wr_sel == SIC_SEL_NONE) ? `SIC_RESP_SLVERR : `SIC_RESP_OKAY;
      unique case (wr_sel)
        SIC_SEL_MASK: begin
          if (lo_en) begin
            st_next.irq_mask = s_axi_wdata[2:0];
          end
        end
        SIC_SEL_ACK: begin
          if (lo_en) begin
            ack_clr[`SIC_BIT_TRANSMIT] = s_axi_wdata[`SIC_BIT_TRANSMIT];
            ack_clr[`SIC_BIT_BLOCK]    = s_axi_wdata[`SIC_BIT_BLOCK];
          end
        end
        SIC_SEL_CRC: begin
          if (hi_en) begin
            st_next.poly_sel   = s_axi_wdata[`SIC_BIT_POLY_HI:`SIC_BIT_POLY_LO];
            st_next.crc_en     = s_axi_wdata[`SIC_BIT_CRC_EN];
            st_next.crc_load   = s_axi_wdata[`SIC_BIT_CRC_LOAD];
            st_next.crc_rx_src = s_axi_wdata[`SIC_BIT_CRC_RX_SRC];
          end
        end
        SIC_SEL_FLAGS, SIC_SEL_NONE: begin
        end
      endcase
    end

    // receive flag clears from the data path; set wins over clear
    ack_clr[`SIC_BIT_RECEIVE] = receive_flag_clear;
    st_next.flags = (st_reg.flags & ~ack_clr) | set_ev;
    st_next.fifo_err = (st_reg.fifo_err && !fifo_init) || fifo_error_event;
    st_next.tx_underflow = st_next.fifo_err && tx_empty;
    st_next.rx_overflow  = st_next.fifo_err && rx_full;
    st_next.irq = |(st_next.flags & st_next.irq_mask);

    // receive length
    st_next.rx_bit_count = (rx_bit_length == 3'h0) ? `SIC_RX_FULL_BYTE
                                                   : {1'b0, rx_bit_length};

    // polynomial decode
    unique case (st_next.poly_sel)
      `SIC_POLY_CCITT: begin
        st_next.crc_gen = `SIC_GEN_CCITT;
        st_next.crc_len = `SIC_LEN_16;
      end
      `SIC_POLY_CRC7: begin
        st_next.crc_gen = `SIC_GEN_CRC7;
        st_next.crc_len = `SIC_LEN_7;
      end
      `SIC_POLY_ALT16: begin
        st_next.crc_gen = `SIC_GEN_ALT16;
        st_next.crc_len = `SIC_LEN_16;
      end
      `SIC_POLY_RSVD: begin
        st_next.crc_gen = `SIC_GEN_CCITT;
        st_next.crc_len = `SIC_LEN_16;
      end
    endcase
    st_next.crc_src_rx = full_duplex && st_next.crc_rx_src;

    // crc value status, upper bits ignored in seven bit mode
    crc_chk = (st_reg.poly_sel == `SIC_POLY_CRC7) ? (crc_value & `SIC_CRC7_MASK) : crc_value;
    st_next.crc_nonzero = (crc_chk != 16'h0000);
    st_next.crc_nonones = (st_reg.poly_sel == `SIC_POLY_CRC7) ? (crc_chk != `SIC_CRC7_MASK)
                                                              : (crc_chk != 16'hffff);

    // read channel
    st_next.arready = 1'b0;
    if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid) begin
      st_next.arready = 1'b1;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_fire) begin
      unique case (rd_sel)
        SIC_SEL_MASK:  rd_word = {13'h0000, st_reg.irq_mask};
        SIC_SEL_FLAGS: rd_word = {8'h00, st_reg.fifo_err, 4'h0, st_reg.flags};
        SIC_SEL_ACK:   rd_word = 16'h0000;
        SIC_SEL_CRC:   rd_word = {st_reg.poly_sel, st_reg.crc_en, 1'b0, st_reg.crc_rx_src,
                                  st_reg.crc_nonzero, st_reg.crc_nonones, 9'h000};
        SIC_SEL_NONE:  rd_word = 16'h0000;
      endcase
      st_next.rvalid = 1'b1;
      st_next.rdata  = {16'h0000, rd_word};
      st_next.rresp  = (rd_sel == SIC_SEL_NONE) ? `SIC_RESP_SLVERR : `SIC_RESP_OKAY;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready     = st_reg.awready;
  assign s_axi_wready      = st_reg.wready;
  assign s_axi_bvalid      = st_reg.bvalid;
  assign s_axi_bresp       = st_reg.bresp;
  assign s_axi_arready     = st_reg.arready;
  assign s_axi_rvalid      = st_reg.rvalid;
  assign s_axi_rdata       = st_reg.rdata;
  assign s_axi_rresp       = st_reg.rresp;
  assign spi_irq           = st_reg.irq;
  assign tx_underflow      = st_reg.tx_underflow;
  assign rx_overflow       = st_reg.rx_overflow;
  assign rx_bit_count      = st_reg.rx_bit_count;
  assign polynomial_select = st_reg.poly_sel;
  assign crc_generator     = st_reg.crc_gen;
  assign crc_length        = st_reg.crc_len;
  assign crc_enable        = st_reg.crc_en;
  assign crc_load_ones     = st_reg.crc_load;
  assign crc_source_rx     = st_reg.crc_src_rx;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // receive length, event flags and mask
  rx_len_a: assert property (rx_bit_length == 3'h0 |=> rx_bit_count == 4'h8)
    else $error("zero receive length not eight bits");
  rx_len_nz_a: assert property (rx_bit_length != 3'h0
                                |=> rx_bit_count == {1'b0, $past(rx_bit_length)})
    else $error("partial receive length wrong");
  irq_gate_a: assert property (byte_transmit_event && st_reg.irq_mask[1]
                               && !(wr_fire && wr_sel == SIC_SEL_MASK) |=> spi_irq)
    else $error("enabled transmit event gave no irq");
  rx_mask_a: assert property (set_ev == 3'h4 && st_reg.flags == 3'h0
                              && !st_reg.irq_mask[2] && !wr_fire |=> !spi_irq)
    else $error("masked receive event raised irq");
  mask_wr_a: assert property (wr_fire && wr_sel == SIC_SEL_MASK && lo_en
                              |=> st_reg.irq_mask == $past(s_axi_wdata[2:0]))
    else $error("mask write not taken");
  tx_flag_a: assert property (byte_transmit_event |=> st_reg.flags[1])
    else $error("transmit event lost");
  rx_flag_a: assert property (byte_receive_event |=> st_reg.flags[2])
    else $error("receive event lost");
  rx_clr_a: assert property (receive_flag_clear && !byte_receive_event
                             |=> !st_reg.flags[2])
    else $error("receive flag not cleared");
  blk_flag_a: assert property (block_transfer_event |=> st_reg.flags[0])
    else $error("block event lost");
  blk_keep_a: assert property (st_reg.flags[0] && !wr_fire
                               |=> st_reg.flags[0])
    else $error("block flag dropped without ack");
  blk_ack_a: assert property (wr_fire && wr_sel == SIC_SEL_ACK && lo_en && s_axi_wdata[0]
                              && !block_transfer_event |=> !st_reg.flags[0])
    else $error("block flag not cleared by ack");
  tx_ack_a: assert property (wr_fire && wr_sel == SIC_SEL_ACK && s_axi_wdata[1]
                             && lo_en && !byte_transmit_event |=> !st_reg.flags[1])
    else $error("transmit flag not cleared by ack");
  ack_zero_a: assert property (wr_fire && wr_sel == SIC_SEL_ACK
                               && s_axi_wdata[1:0] == 2'h0 && !receive_flag_clear
                               |=> st_reg.flags == ($past(st_reg.flags) | $past(set_ev)))
    else $error("ack zero changed flags");

  // fifo error
  fifo_set_a: assert property (fifo_error_event |=> st_reg.fifo_err)
    else $error("fifo error event lost");
  fifo_keep_a: assert property (st_reg.fifo_err && !fifo_init |=> st_reg.fifo_err)
    else $error("fifo error dropped without init");
  tx_under_a: assert property (st_reg.fifo_err && !fifo_init && tx_empty
                               |=> tx_underflow)
    else $error("underflow not reported");
  rx_over_a: assert property (st_reg.fifo_err && !fifo_init && rx_full
                              |=> rx_overflow)
    else $error("overflow not reported");
  fifo_init_a: assert property (fifo_init && !fifo_error_event
                                |=> !st_reg.fifo_err && !tx_underflow && !rx_overflow)
    else $error("fifo init did not clear error");

  // crc control
  crc_load_a: assert property (crc_load_ones |=> !crc_load_ones)
    else $error("crc load not self clearing");
  load_set_a: assert property (wr_fire && wr_sel == SIC_SEL_CRC && hi_en
                               && s_axi_wdata[`SIC_BIT_CRC_LOAD] |=> crc_load_ones)
    else $error("crc load strobe missing");
  load_read_a: assert property (rd_fire && rd_sel == SIC_SEL_CRC
                                |=> !s_axi_rdata[`SIC_BIT_CRC_LOAD])
    else $error("crc load bit read back");
  crc_en_a: assert property (wr_fire && wr_sel == SIC_SEL_CRC && hi_en
                             |=> crc_enable == $past(s_axi_wdata[`SIC_BIT_CRC_EN]))
    else $error("crc enable not taken");
  poly_wr_a: assert property (wr_fire && wr_sel == SIC_SEL_CRC && hi_en
                              |=> polynomial_select == $past(s_axi_wdata[15:14]))
    else $error("polynomial select not taken");
  poly7_a: assert property (polynomial_select == `SIC_POLY_CRC7
                            |-> crc_length == `SIC_LEN_7 && crc_generator == `SIC_GEN_CRC7)
    else $error("seven bit mode length wrong");
  src_half_a: assert property (!full_duplex |=> !crc_source_rx)
    else $error("crc source rx in half duplex");
  nonzero_a: assert property ($past(crc_value) == 16'h0000 |-> !st_reg.crc_nonzero)
    else $error("nonzero flag set for zero crc");
  nonones_a: assert property ($past(crc_value) == 16'hffff
                              && $past(polynomial_select) != `SIC_POLY_CRC7 |-> !st_reg.crc_nonones)
    else $error("not-ones flag set for all ones");

  // axi handshake
  rd_resp_a: assert property (rd_fire |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read answer missing");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write ready held over two cycles");
  aw_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready apart");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read ready held over two cycles");
  b_answer_a: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write answer missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
                             |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
                             |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while response pending");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  wr_err_a: assert property (wr_fire && wr_sel == SIC_SEL_NONE
                             |=> s_axi_bresp == `SIC_RESP_SLVERR)
    else $error("unmapped write not refused");
  rd_err_a: assert property (rd_fire && rd_sel == SIC_SEL_NONE
                             |=> s_axi_rresp == `SIC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  ack_read_a: assert property (rd_fire && rd_sel == SIC_SEL_ACK |=> s_axi_rdata == 32'h0)
    else $error("ack register read not zero");

  irq_c: cover property (byte_receive_event ##1 spi_irq);
  ack_c: cover property (wr_fire && wr_sel == SIC_SEL_ACK ##2 !st_reg.flags[1]);
  under_c: cover property (tx_underflow);
  crc7_c: cover property (polynomial_select == 2'h1 && crc_enable);
  fifo_c: cover property (fifo_init && st_reg.fifo_err);

endmodule : sic_top

`default_nettype wire

// *** verif/sic_top_test.sv ***
// self-checking bench of the spi interrupt and crc control block
// assumes sic_top, sic_pkg and sic_map.svh compiled before it
`include "sic_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sic_top_test
  import sic_pkg::*;
;
  localparam logic [19:0] A_MASK  = {2'b00, `SIC_IDX_IRQ_MASK, 2'b00};
  localparam logic [19:0] A_FLAGS = {2'b00, `SIC_IDX_EVENT_FLAGS, 2'b00};
  localparam logic [19:0] A_ACK   = {2'b00, `SIC_IDX_EVENT_ACK, 2'b00};
  localparam logic [19:0] A_CRC   = {2'b00, `SIC_IDX_CHECKSUM, 2'b00};
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [19:0] awaddr = '0, araddr = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic        awready, wready, bvalid, arready, rvalid, irq, tx_uf, rx_of;
  logic        crc_en, crc_ld, crc_rx;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd_d;
  logic [3:0]  rx_cnt;
  sic_poly_t   poly;
  logic [15:0] gen;
  logic [4:0]  len;
  logic [2:0]  ev = '0, rxlen = '0;
  logic        rx_clr = 0, fe = 0, finit = 0, tx_empty = 0, rx_full = 0, fdx = 0;
  logic [15:0] crcv = 16'h1234;
  logic [15:0] gen_t [4] = '{16'h1021, 16'h0009, 16'h8005, 16'h1021};
  int          n_errors = 0, num_checks = 0, n_load = 0, n0;

  sic_top dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .byte_receive_event(ev[2]), .byte_transmit_event(ev[1]),
    .block_transfer_event(ev[0]), .receive_flag_clear(rx_clr),
    .fifo_error_event(fe), .fifo_init(finit), .tx_empty(tx_empty), .rx_full(rx_full),
    .full_duplex(fdx), .rx_bit_length(rxlen), .crc_value(crcv), .spi_irq(irq),
    .tx_underflow(tx_uf), .rx_overflow(rx_of), .rx_bit_count(rx_cnt),
    .polynomial_select(poly), .crc_generator(gen), .crc_length(len),
    .crc_enable(crc_en), .crc_load_ones(crc_ld), .crc_source_rx(crc_rx)
  );

  always #12.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (crc_ld === 1'b1) n_load <= n_load + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (awready === 1'b1 && !aw_ok) begin
        awvalid <= 0;
        aw_ok = 1;
      end
      if (wready === 1'b1 && !w_ok) begin
        wvalid <= 0;
        w_ok = 1;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [19:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rd_d = rdata;
    resp = rresp;
    rready <= 0;
  endtask : rd

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    #500000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rd(A_MASK);
    chk("mask reset", 0, rd_d);
    rd(A_FLAGS);
    chk("flags reset", 0, rd_d);
    rd(A_ACK);
    chk("ack read", 0, rd_d);
    rd(A_CRC);
    chk("crc setup reset", 32'h0600, rd_d);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      rxlen <= 3'(i);
      repeat (2) @(posedge clk_sys);
      chk("rx_bit_count", (i == 0) ? 8 : i, 32'(rx_cnt));
    end
    $display("test receive length done");
    for (int b = 0; b < 3; b++) begin
      ev <= 3'(1 << b);
      @(posedge clk_sys);
      ev <= '0;
      wr(A_MASK, 32'(7 & ~(1 << b)));
      rd(A_FLAGS);
      chk("flags set", 1 << b, rd_d);
      chk("irq masked", 0, 32'(irq));
      wr(A_MASK, 32'(1 << b));
      rd(A_MASK);
      chk("mask", 1 << b, rd_d);
      chk("irq", 1, 32'(irq));
      if (b < 2) begin
        wr(A_ACK, 0);
        rd(A_FLAGS);
        chk("flags kept", 1 << b, rd_d);
        wr(A_ACK, 32'(1 << b));
      end else begin
        rx_clr <= 1;
        @(posedge clk_sys);
        rx_clr <= 0;
      end
      rd(A_FLAGS);
      chk("flags cleared", 0, rd_d);
      chk("irq off", 0, 32'(irq));
      wr(A_MASK, 0);
    end
    $display("test events done");
    fe <= 1;
    tx_empty <= 1;
    @(posedge clk_sys);
    fe <= 0;
    repeat (2) @(posedge clk_sys);
    chk("tx_underflow", 1, 32'(tx_uf));
    chk("rx_overflow", 0, 32'(rx_of));
    tx_empty <= 0;
    rx_full <= 1;
    repeat (2) @(posedge clk_sys);
    chk("rx_overflow", 1, 32'(rx_of));
    chk("tx_underflow", 0, 32'(tx_uf));
    wr(A_FLAGS, 0);
    rd(A_FLAGS);
    chk("fifo error", 32'h80, rd_d);
    finit <= 1;
    @(posedge clk_sys);
    finit <= 0;
    rd(A_FLAGS);
    chk("fifo error init", 0, rd_d);
    $display("test fifo error done");
    for (int c = 0; c < 4; c++) begin
      wr(A_CRC, {16'h0, 2'(c), 14'h2000});
      rd(A_CRC);
      chk("crc setup", {16'h0, 2'(c), 14'h2600}, rd_d);
      chk("poly", c, 32'(poly));
      chk("generator", 32'(gen_t[c]), 32'(gen));
      chk("length", (c == 1) ? 7 : 16, 32'(len));
      chk("crc enable", 1, 32'(crc_en));
    end
    crcv <= 16'h0000;
    rd(A_CRC);
    chk("crc zero", 32'he200, rd_d);
    crcv <= 16'hffff;
    rd(A_CRC);
    chk("crc ones", 32'he400, rd_d);
    n0 = n_load;
    wr(A_CRC, 32'h1000);
    repeat (2) @(posedge clk_sys);
    chk("load pulses", 1, 32'(n_load - n0));
    chk("crc disabled", 0, 32'(crc_en));
    rd(A_CRC);
    chk("load reads zero", 32'h0400, rd_d);
    fdx <= 1;
    wr(A_CRC, 32'h0800);
    repeat (2) @(posedge clk_sys);
    chk("source rx", 1, 32'(crc_rx));
    fdx <= 0;
    repeat (2) @(posedge clk_sys);
    chk("source half duplex", 0, 32'(crc_rx));
    $display("test crc done");
    wr(A_MASK, 32'h7);
    ev <= 3'h7;
    repeat (2) @(posedge clk_sys);
    ev <= '0;
    chk("irq before reset", 1, 32'(irq));
    rst_n <= 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    chk("irq after reset", 0, 32'(irq));
    rd(A_MASK);
    chk("mask after reset", 0, rd_d);
    rd(A_FLAGS);
    chk("flags after reset", 0, rd_d);
    rd(A_CRC);
    chk("crc after reset", 32'h0400, rd_d);
    $display("test mid reset done");
    wr(20'h00000, 32'h1);
    chk("bresp unmapped", 2, 32'(resp));
    rd(20'h00000);
    chk("rresp unmapped", 2, 32'(resp));
    chk("rdata unmapped", 0, rd_d);
    $display("test unmapped done");
    give_verdict();
  end
endmodule : sic_top_test

`default_nettype wire
